// file: tmg_top.sv
// tmg_top: mode register, pair control, power gating and source clock
// selection of the upper timer in a cascadable pair.
// assumes a synchronous byte register port and a 10 MHz core clock.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module tmg_top
  import tmg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [7:0]       rdata,
  input  wire logic        lf_clk_pin,
  input  wire logic        event_input_pin,
  output logic             src_tick,
  output logic             src_valid,
  output logic             double_buffer_on,
  output logic [7:0]       compare_value,
  output logic [2:0]       op_mode,
  output logic             cascade_on,
  output logic             timer_run,
  output logic             out_ff,
  output logic             pwm_output_pin,
  output logic             pulse_output_pin,
  output logic             pair_a_on,
  output logic             pair_b_on,
  output logic             capture_a_on,
  output logic             capture_b_on
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  cmp_q;
  logic [7:0]  cmp_buf_q;
  logic [7:0]  mode_q;
  logic [3:0]  pair_q;
  logic [7:0]  gate_q;
  logic [7:0]  sys_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        ff_q;
  logic [2:0]  ev_sync_q;
  logic [11:0] gear_tick;
  logic [4:0]  lf_tick;

  logic        wr_cmp;
  logic        wr_mode;
  logic        wr_pair;
  logic        wr_gate;
  logic        wr_sys;
  logic        running;
  logic        run_start;
  logic [2:0]  ck_sel;
  logic        subst;
  logic        slow_mode;
  logic        ext_sel;
  logic        ev_fall;
  logic        int_tick;
  logic        int_valid;
  logic [1:0]  op_code;
  logic        waveform;
  tmg_op_t     op_sel;

  tmg_clk_div u_div (
    .core_clk   (core_clk),
    .rst        (rst),
    .lf_clk_pin (lf_clk_pin),
    .gear_tick  (gear_tick),
    .lf_tick    (lf_tick)
  );

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign wr_cmp    = wr_stb & (addr == TMG_ADDR_COMPARE);
  assign wr_mode   = wr_stb & (addr == TMG_ADDR_MODE);
  assign wr_pair   = wr_stb & (addr == TMG_ADDR_PAIR);
  assign wr_gate   = wr_stb & (addr == TMG_ADDR_GATING);
  assign wr_sys    = wr_stb & (addr == TMG_ADDR_SYSCFG);
  assign running   = pair_q[TMG_PAIR_RUN1] | pair_q[TMG_PAIR_RUN0];
  assign run_start = wr_pair & ~running & wdata[TMG_PAIR_RUN1];

  always_comb begin
    case (addr)
      TMG_ADDR_COMPARE: rdata_d = cmp_q;
      TMG_ADDR_MODE:    rdata_d = mode_q;
      TMG_ADDR_PAIR:    rdata_d = {4'h0, pair_q};
      TMG_ADDR_GATING:  rdata_d = gate_q;
      TMG_ADDR_SYSCFG:  rdata_d = sys_q;
      default:          rdata_d = 8'h00;
    endcase
  end
  assign rdata = rdata_q;

  // ---------------------------------------------------------------
  // source clock selection
  // ---------------------------------------------------------------
  assign ck_sel    = mode_q[TMG_MODE_CKHI:TMG_MODE_CKLO];
  assign subst     = sys_q[TMG_SYS_SUBST];
  assign slow_mode = sys_q[TMG_SYS_SLOW];
  assign ext_sel   = mode_q[TMG_MODE_EXT];
  assign ev_fall   = ev_sync_q[2] & ~ev_sync_q[1];

  always_comb begin
    int_valid = 1'b1;
    int_tick  = 1'b0;
    if (slow_mode) begin
      case (ck_sel)
        3'h0:    int_tick = lf_tick[4];
        3'h1:    int_tick = lf_tick[3];
        3'h7:    int_tick = lf_tick[2];
        default: int_valid = 1'b0;
      endcase
    end else begin
      case (ck_sel)
        3'h0:    int_tick = subst ? lf_tick[4] : gear_tick[11];
        3'h1:    int_tick = subst ? lf_tick[3] : gear_tick[10];
        3'h2:    int_tick = gear_tick[8];
        3'h3:    int_tick = gear_tick[6];
        3'h4:    int_tick = gear_tick[4];
        3'h5:    int_tick = gear_tick[2];
        3'h6:    int_tick = gear_tick[1];
        default: int_tick = gear_tick[0];
      endcase
    end
  end

  // external select overrides divider field
  assign src_valid = pair_a_on & (ext_sel | int_valid);
  assign src_tick  = timer_run & src_valid & (ext_sel ? ev_fall : int_tick);

  // ---------------------------------------------------------------
  // operating mode
  // ---------------------------------------------------------------
  assign op_code    = mode_q[TMG_MODE_OPHI:TMG_MODE_OPLO];
  assign cascade_on = pair_q[TMG_PAIR_CAS];

  always_comb begin
    case ({cascade_on, op_code})
      3'b010:  op_sel = TMG_OP_PWM8;
      3'b011:  op_sel = TMG_OP_PPG8;
      3'b100:  op_sel = TMG_OP_TIMER16;
      3'b101:  op_sel = TMG_OP_TIMER16;
      3'b110:  op_sel = TMG_OP_PWM12;
      3'b111:  op_sel = TMG_OP_PPG16;
      default: op_sel = TMG_OP_TIMER8;
    endcase
  end
  assign op_mode  = op_sel;
  assign waveform = op_code[1];

  assign timer_run        = pair_q[TMG_PAIR_RUN1];
  assign double_buffer_on = mode_q[TMG_MODE_DBE];
  assign compare_value    = cmp_buf_q;
  assign out_ff           = ff_q;
  assign pwm_output_pin   = waveform ? ff_q : 1'b1;
  assign pulse_output_pin = waveform ? ff_q : 1'b1;
  assign pair_a_on        = gate_q[TMG_GATE_PAIRA];
  assign pair_b_on        = gate_q[TMG_GATE_PAIRB];
  assign capture_a_on     = gate_q[TMG_GATE_CAPA];
  assign capture_b_on     = gate_q[TMG_GATE_CAPB];

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmp_q     <= TMG_RST_COMPARE;
      cmp_buf_q <= TMG_RST_COMPARE;
      mode_q    <= TMG_RST_MODE;
      pair_q    <= TMG_RST_PAIR[TMG_PAIR_WIDTH-1:0];
      gate_q    <= TMG_RST_GATING;
      sys_q     <= TMG_RST_SYSCFG;
      rdata_q   <= 8'h00;
      ff_q      <= 1'b0;
      ev_sync_q <= '0;
    end else begin
      rdata_q   <= rd_stb ? rdata_d : 8'h00;
      ev_sync_q <= {ev_sync_q[1:0], event_input_pin};
      if (wr_cmp) begin
        cmp_q <= wdata;
      end
      // buffered copy loads while double buffering is off or while stopped
      if (!double_buffer_on || !timer_run) begin
        cmp_buf_q <= wr_cmp ? wdata : cmp_q;
      end
      if (wr_mode && !running) begin
        mode_q <= wdata;
      end
      if (wr_pair) begin
        pair_q[TMG_PAIR_RUN1:TMG_PAIR_RUN0] <= wdata[1:0];
        if (!running) begin
          pair_q[3:2] <= wdata[3:2];
        end
      end
      if (wr_gate) begin
        gate_q <= wdata;
      end
      if (wr_sys) begin
        sys_q <= wdata;
      end
      if (!timer_run || run_start) begin
        ff_q <= waveform & mode_q[TMG_MODE_FF];
      end
    end
  end

endmodule

// file: tmg_pkg.sv
// tmg_pkg: register map, field layout and timing constants of the upper
// timer mode and power gating block.
// assumes a byte-wide register port and one 10 MHz core clock.
package tmg_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] TMG_ADDR_COMPARE = 12'h029;
  localparam logic [11:0] TMG_ADDR_MODE    = 12'h02B;
  localparam logic [11:0] TMG_ADDR_PAIR    = 12'h02C;
  localparam logic [11:0] TMG_ADDR_GATING  = 12'hF74;
  localparam logic [11:0] TMG_ADDR_SYSCFG  = 12'hF80;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] TMG_RST_COMPARE = 8'hFF;
  localparam logic [7:0] TMG_RST_MODE    = 8'h00;
  localparam logic [7:0] TMG_RST_PAIR    = 8'h00;
  localparam logic [7:0] TMG_RST_GATING  = 8'h00;
  localparam logic [7:0] TMG_RST_SYSCFG  = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TMG_MODE_FF    = 7;
  localparam int TMG_MODE_DBE   = 6;
  localparam int TMG_MODE_CKHI  = 5;
  localparam int TMG_MODE_CKLO  = 3;
  localparam int TMG_MODE_EXT   = 2;
  localparam int TMG_MODE_OPHI  = 1;
  localparam int TMG_MODE_OPLO  = 0;
  localparam int TMG_PAIR_CAS   = 2;
  localparam int TMG_PAIR_RUN1  = 1;
  localparam int TMG_PAIR_RUN0  = 0;
  localparam int TMG_PAIR_WIDTH = 4;
  localparam int TMG_GATE_PAIRB = 5;
  localparam int TMG_GATE_PAIRA = 4;
  localparam int TMG_GATE_CAPB  = 1;
  localparam int TMG_GATE_CAPA  = 0;
  localparam int TMG_SYS_SUBST  = 0;
  localparam int TMG_SYS_SLOW   = 1;

  // ---------------------------------------------------------------
  // prescaler and low clock
  // ---------------------------------------------------------------
  localparam int TMG_PRESCALE_BITS = 11;
  localparam int TMG_LF_HALF_NS    = 15259;
  localparam int TMG_CLK_NS        = 100;
  localparam int TMG_LF_HALF_CYC   = TMG_LF_HALF_NS / TMG_CLK_NS;

  typedef enum logic [2:0] {
    TMG_OP_TIMER8,
    TMG_OP_PWM8,
    TMG_OP_PPG8,
    TMG_OP_TIMER16,
    TMG_OP_PWM12,
    TMG_OP_PPG16
  } tmg_op_t;

endpackage

// file: tmg_clk_div.sv
// tmg_clk_div: free running prescaler for the gear clock and the
// low-frequency clock, with one-cycle tick outputs.
// assumes the low-frequency clock is a level from another domain.
`timescale 1ns/100ps
module tmg_clk_div
  import tmg_pkg::*;
#(
  parameter int LF_HALF = TMG_LF_HALF_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        lf_clk_pin,
  output logic [11:0]      gear_tick,
  output logic [4:0]       lf_tick
);

  // ---------------------------------------------------------------
  // gear prescaler: tick k fires once every 2^k cycles
  // ---------------------------------------------------------------
  logic [TMG_PRESCALE_BITS-1:0] gear_q;
  logic [TMG_PRESCALE_BITS-1:0] gear_d;
  logic [TMG_PRESCALE_BITS:0]   gear_t;
  logic [2:0]                   lf_sync_q;
  logic [3:0]                   lf_cnt_q;
  logic [3:0]                   lf_cnt_d;
  logic                         lf_fall;

  assign gear_d = gear_q + 1'b1;

  assign gear_t[0] = 1'b1;
  for (genvar k = 1; k <= TMG_PRESCALE_BITS; k++) begin : g_tick
    assign gear_t[k] = &gear_q[k-1:0];
  end
  assign gear_tick = gear_t;

  // ---------------------------------------------------------------
  // low-frequency clock: synchronise, then divide falling edges
  // ---------------------------------------------------------------
  assign lf_fall  = lf_sync_q[2] & ~lf_sync_q[1];
  assign lf_cnt_d = lf_cnt_q + 4'h1;
  assign lf_tick  = {lf_fall & (lf_cnt_q == 4'hF),
                     lf_fall & (lf_cnt_q[2:0] == 3'h7),
                     lf_fall & (lf_cnt_q[1:0] == 2'h3),
                     lf_fall & lf_cnt_q[0],
                     lf_fall};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gear_q    <= '0;
      lf_sync_q <= '0;
      lf_cnt_q  <= '0;
    end else begin
      gear_q    <= gear_d;
      lf_sync_q <= {lf_sync_q[1:0], lf_clk_pin};
      if (lf_fall) begin
        lf_cnt_q <= lf_cnt_d;
      end
    end
  end

endmodule

// file: tmg_top_monitor.sv
// tmg_top_monitor: port-level checks of tmg_top
// assumes tmg_pkg is compiled first; bound to every tmg_top
`timescale 1ns/100ps
module tmg_top_monitor
  import tmg_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [11:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  rdata,
  input wire logic        src_tick,
  input wire logic        src_valid,
  input wire logic        double_buffer_on,
  input wire logic [7:0]  compare_value,
  input wire logic [2:0]  op_mode,
  input wire logic        cascade_on,
  input wire logic        timer_run,
  input wire logic        out_ff,
  input wire logic        pwm_output_pin,
  input wire logic        pulse_output_pin,
  input wire logic        pair_a_on,
  input wire logic        pair_b_on,
  input wire logic        capture_a_on,
  input wire logic        capture_b_on
);
  // ------------------
  // checks
  // ------------------
  logic [7:0] wdata_q;
  wire        is_timer = op_mode == TMG_OP_TIMER8 || op_mode == TMG_OP_TIMER16;

  always_ff @(posedge core_clk) begin
    wdata_q <= wdata;
  end

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  rd_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  mode_lock_a: assert property (
    wr_stb && addr == TMG_ADDR_MODE && timer_run
    |=> $stable(op_mode) && $stable(double_buffer_on))
    else $error("mode taken");
  cas_lock_a: assert property (
    wr_stb && addr == TMG_ADDR_PAIR && timer_run |=> $stable(cascade_on))
    else $error("cascade changed while running");
  run_bit_a: assert property (wr_stb && addr == TMG_ADDR_PAIR
    |=> timer_run == wdata_q[1]) else $error("run bit not taken");
  gate_bits_a: assert property (wr_stb && addr == TMG_ADDR_GATING
    |=> {pair_b_on, pair_a_on, capture_b_on, capture_a_on}
        == {wdata_q[5], wdata_q[4], wdata_q[1], wdata_q[0]})
    else $error("gating outputs wrong");
  mode_width_a: assert property (
    cascade_on ? op_mode inside {[3:5]} : op_mode <= 3'd2)
    else $error("mode width wrong");
  timer_pins_a: assert property (is_timer
    |-> pwm_output_pin && pulse_output_pin) else $error("pins low in timer");
  wave_pins_a: assert property (!is_timer
    |-> pwm_output_pin == out_ff && pulse_output_pin == out_ff)
    else $error("pins differ from flip-flop");
  dbuf_hold_a: assert property ((double_buffer_on && timer_run)[*2]
    |-> $stable(compare_value)) else $error("compare changed");
  valid_gate_a: assert property (src_valid |-> pair_a_on)
    else $error("source valid while pair gated");

  cover property (wr_stb && addr == TMG_ADDR_MODE && timer_run);
  cover property (src_tick && timer_run);
  cover property (cascade_on && timer_run);
endmodule

bind tmg_top tmg_top_monitor tmg_top_monitor_i (
  .core_clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .src_tick,
  .src_valid, .double_buffer_on, .compare_value, .op_mode, .cascade_on,
  .timer_run, .out_ff, .pwm_output_pin, .pulse_output_pin, .pair_a_on,
  .pair_b_on, .capture_a_on, .capture_b_on
);

// file: tb.sv
// tb: self-checking bench for tmg_top
// assumes tmg_pkg, the design and the checker are compiled first
`timescale 1ns/100ps
module tb import tmg_pkg::*;;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        lf_clk_pin = 1'b0;
  logic        event_input_pin = 1'b1;
  logic [7:0]  rdata, compare_value;
  logic [2:0]  op_mode;
  logic        src_tick, src_valid, double_buffer_on, cascade_on, timer_run;
  logic        out_ff, pwm_output_pin, pulse_output_pin;
  logic        pair_a_on, pair_b_on, capture_a_on, capture_b_on;
  int          error_cnt = 0;
  int          total_checks = 0;
  wire [7:0]   gate_o = {4'h0, pair_b_on, pair_a_on,
                         capture_b_on, capture_a_on};
  wire [7:0]   pins_o = {6'h00, pwm_output_pin, pulse_output_pin};

  tmg_top tmg_top_i (
    .core_clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .lf_clk_pin,
    .event_input_pin, .src_tick, .src_valid, .double_buffer_on,
    .compare_value, .op_mode, .cascade_on, .timer_run, .out_ff,
    .pwm_output_pin, .pulse_output_pin, .pair_a_on, .pair_b_on,
    .capture_a_on, .capture_b_on
  );

  // ------------------
  // bus and compare
  // ------------------
  always #50 core_clk = ~core_clk;

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic tick_chk(input int n, input int e);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge core_clk);
      c += int'(src_tick === 1'b1);
    end
    chk(c[7:0], e[7:0]);
  endtask

  // ------------------
  // scenarios
  // ------------------
  task automatic t_reset();
    rd_chk(TMG_ADDR_COMPARE, 8'hFF);
    rd_chk(TMG_ADDR_MODE, 8'h00);
    rd_chk(TMG_ADDR_PAIR, 8'h00);
    rd_chk(TMG_ADDR_GATING, 8'h00);
    rd_chk(12'h100, 8'h00);
    chk(pins_o, 8'h03);
  endtask

  task automatic t_gating();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      wr(TMG_ADDR_GATING, v);
      rd_chk(TMG_ADDR_GATING, v);
      chk(gate_o, {4'h0, v[5], v[4], v[1], v[0]});
    end
    wr(TMG_ADDR_GATING, 8'h00);
  endtask

  task automatic t_modes();
    logic [2:0] e;
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        wr(TMG_ADDR_PAIR, 8'(c << 2));
        wr(TMG_ADDR_MODE, {m[0], 5'h00, m[1:0]});
        e = (m < 2) ? 3'd0 : 3'(m - 1);
        if (c == 1) e = e + 3'd3;
        chk({7'h00, cascade_on}, 8'(c));
        chk({5'h00, op_mode}, {5'h00, e});
        @(posedge core_clk);
        #1;
        chk(pins_o, (m < 2) ? 8'h03 : {6'h00, {2{m[0]}}});
        chk({7'h00, out_ff}, 8'((m > 1) && m[0]));
      end
    end
    wr(TMG_ADDR_PAIR, 8'h00);
  endtask

  task automatic t_refuse();
    wr(TMG_ADDR_MODE, 8'h40);
    chk({7'h00, double_buffer_on}, 8'h01);
    wr(TMG_ADDR_PAIR, 8'hF6);
    chk({7'h00, timer_run}, 8'h01);
    rd_chk(TMG_ADDR_PAIR, 8'h06);
    wr(TMG_ADDR_COMPARE, 8'h55);
    chk(compare_value, 8'hFF);
    wr(TMG_ADDR_MODE, 8'h00);
    rd_chk(TMG_ADDR_MODE, 8'h40);
    wr(TMG_ADDR_PAIR, 8'h02);
    rd_chk(TMG_ADDR_PAIR, 8'h06);
    wr(TMG_ADDR_PAIR, 8'h00);
    rd_chk(TMG_ADDR_PAIR, 8'h04);
    chk(compare_value, 8'h55);
    wr(TMG_ADDR_PAIR, 8'h00);
    wr(TMG_ADDR_MODE, 8'h00);
    rd_chk(TMG_ADDR_MODE, 8'h00);
  endtask

  task automatic t_src();
    wr(TMG_ADDR_GATING, 8'h10);
    wr(TMG_ADDR_MODE, 8'h38);
    wr(TMG_ADDR_PAIR, 8'h02);
    tick_chk(64, 64);
    wr(TMG_ADDR_PAIR, 8'h00);
    wr(TMG_ADDR_MODE, 8'h30);
    wr(TMG_ADDR_PAIR, 8'h02);
    tick_chk(64, 32);
    wr(TMG_ADDR_PAIR, 8'h00);
    wr(TMG_ADDR_MODE, 8'h3C);
    wr(TMG_ADDR_PAIR, 8'h02);
    fork
      tick_chk(60, 5);
      repeat (5) begin
        repeat (4) @(posedge core_clk);
        event_input_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        event_input_pin <= 1'b1;
      end
    join
    wr(TMG_ADDR_PAIR, 8'h00);
    wr(TMG_ADDR_SYSCFG, 8'h02);
    wr(TMG_ADDR_MODE, 8'h10);
    chk({7'h00, src_valid}, 8'h00);
    wr(TMG_ADDR_MODE, 8'h38);
    chk({7'h00, src_valid}, 8'h01);
    wr(TMG_ADDR_GATING, 8'h00);
    chk({7'h00, src_valid}, 8'h00);
    wr(TMG_ADDR_SYSCFG, 8'h00);
  endtask

  task automatic lf_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      lf_clk_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      lf_clk_pin <= 1'b0;
    end
  endtask

  task automatic t_slow();
    wr(TMG_ADDR_GATING, 8'h10);
    wr(TMG_ADDR_SYSCFG, 8'h02);
    wr(TMG_ADDR_MODE, 8'h38);
    wr(TMG_ADDR_PAIR, 8'h02);
    fork
      tick_chk(72, 2);
      lf_pulses(8);
    join
    wr(TMG_ADDR_PAIR, 8'h00);
    wr(TMG_ADDR_SYSCFG, 8'h01);
    wr(TMG_ADDR_MODE, 8'h08);
    wr(TMG_ADDR_PAIR, 8'h02);
    fork
      tick_chk(72, 1);
      lf_pulses(8);
    join
    wr(TMG_ADDR_PAIR, 8'h00);
    wr(TMG_ADDR_SYSCFG, 8'h00);
    wr(TMG_ADDR_GATING, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_gating();
    t_modes();
    t_refuse();
    t_src();
    t_slow();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
